// File: core/ris_input_stage.sv
`timescale 1ns/1ns
`default_nettype none
`include "ris_cfg.svh"
// reference input stages: mode decode, index mapping, dividers
module ris_input_stage
    import ris_pkg::*;
(
    input  wire logic                                 clk,
    input  wire logic                                 sys_rst,
    input  wire logic [`RIS_NUM_STAGES-1:0]           ref_p,
    input  wire logic [`RIS_NUM_STAGES-1:0]           ref_n,
    input  wire logic                                 gpio0_in,
    input  wire logic                                 gpio3_in,
    input  wire logic [2*`RIS_NUM_STAGES-1:0]         stage_mode,
    input  wire logic [`RIS_NUM_STAGES-1:0]           swing_nmos,
    input  wire logic [`RIS_NUM_REFS-1:0]             ref_disable,
    input  wire logic [`RIS_NUM_REFS-1:0]             ref_invert,
    input  wire logic [`RIS_NUM_REFS-1:0]             div_bypass,
    input  wire logic [`RIS_NUM_REFS*`RIS_DIV_W-1:0]  div_count,
    input  wire logic [`RIS_NUM_REFS-1:0]             sync_role,
    input  wire logic [`RIS_NUM_REFS*4-1:0]           sync_assoc,
    input  wire logic [`RIS_NUM_REFS*`RIS_FREQ_M_W-1:0]
                                                      input_nominal_frequency_m,
    input  wire logic [`RIS_NUM_REFS*`RIS_FREQ_N_W-1:0]
                                                      input_nominal_frequency_n,
    input  wire logic                                 otp_en,
    input  wire logic                                 otp_valid,
    input  wire logic                                 otp_dbl,
    input  wire logic [`RIS_FB_W-1:0]                 otp_fb,
    input  wire logic                                 eep_en,
    input  wire logic                                 eep_valid,
    input  wire logic                                 eep_dbl,
    input  wire logic [`RIS_FB_W-1:0]                 eep_fb,
    input  wire logic                                 pll_wr,
    input  wire logic                                 pll_wr_dbl,
    input  wire logic [`RIS_FB_W-1:0]                 pll_wr_fb,
    input  wire logic                                 pll_lock,
    input  wire logic                                 lol_route_en,
    output logic [`RIS_NUM_REFS-1:0]                  ref_clk,
    output logic [`RIS_NUM_REFS-1:0]                  sync_pulse,
    output logic [`RIS_NUM_REFS*4-1:0]                sync_ref,
    output logic [`RIS_NUM_STAGES-1:0]                rx_nmos,
    output logic [`RIS_NUM_STAGES-1:0]                rx_diff,
    output logic [`RIS_NUM_REFS*`RIS_FREQ_M_W-1:0]    freq_m,
    output logic [`RIS_NUM_REFS*`RIS_FREQ_N_W-1:0]    freq_n,
    output logic                                      system_pll_doubler,
    output logic [`RIS_FB_W-1:0]                      system_pll_feedback,
    output logic                                      pll_ctl_ready,
    output logic                                      pll_lol_status,
    output logic                                      pll_lol_gpio
);
    // two-flop synchronisers on every pin input
    logic [`RIS_NUM_STAGES-1:0] p_s1, p_s2; // positive pins
    logic [`RIS_NUM_STAGES-1:0] n_s1, n_s2; // negative pins
    logic [1:0]                 g_s1, g_s2; // gpio 0 and 3
    logic                       lk_s1, lk_s2; // analog lock level

    // effective mode per stage after legality filter
    ris_mode_e                  mode [`RIS_NUM_STAGES];
    // per-reference path inputs
    logic [`RIS_NUM_REFS-1:0]   src;    // routed pin sample
    logic [`RIS_NUM_REFS-1:0]   act;    // reference exists in mode
    logic [`RIS_NUM_REFS-1:0]   nodiv;  // forced bypass
    logic [`RIS_NUM_REFS-1:0]   path_out; // divider path results

    // input synchronisers; nothing reads the first stage but the second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            p_s1 <= '0;
            p_s2 <= '0;
            n_s1 <= '0;
            n_s2 <= '0;
            g_s1 <= '0;
            g_s2 <= '0;
        end else begin
            p_s1 <= ref_p;
            p_s2 <= p_s1;
            n_s1 <= ref_n;
            n_s2 <= n_s1;
            g_s1 <= {gpio3_in, gpio0_in};
            g_s2 <= g_s1;
        end
    end

    // lock indicator synchroniser
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lk_s1 <= 1'b0;
            lk_s2 <= 1'b0;
        end else begin
            lk_s1 <= pll_lock;
            lk_s2 <= lk_s1;
        end
    end

    // per-stage mode filter and routing
    genvar s;
    generate
        for (s = 0; s < `RIS_NUM_STAGES; s++) begin : g_stage
            logic [1:0] raw;    // requested mode
            logic       has_pin; // stage with a gpio pairing
            assign raw = stage_mode[2*s +: 2];
            assign has_pin = (s == `RIS_PIN0_STAGE) ||
                             (s == `RIS_PIN3_STAGE);
            // pin mode only where paired; otherwise fall to diff
            always_comb begin
                if (raw == RIS_MODE_DUAL) begin
                    mode[s] = RIS_MODE_DUAL;
                end else if (raw == RIS_MODE_PIN && has_pin) begin
                    mode[s] = RIS_MODE_PIN;
                end else begin
                    mode[s] = RIS_MODE_DIFF;
                end
            end
            // low index: positive pin or diff pair, same number
            // stage 7 in pin mode carries no diff pair; its pin mode only feeds 15
            assign src[s] = p_s2[s];
            assign act[s] = !(s == `RIS_PIN3_STAGE && mode[s] == RIS_MODE_PIN);
            // high index: negative pin, or the gpio in pin mode
            always_comb begin
                if (mode[s] == RIS_MODE_DUAL) begin
                    src[s + `RIS_NEG_OFFSET] = n_s2[s];
                    act[s + `RIS_NEG_OFFSET] = 1'b1;
                end else if (mode[s] == RIS_MODE_PIN) begin
                    src[s + `RIS_NEG_OFFSET] =
                        (s == `RIS_PIN0_STAGE) ? g_s2[0] : g_s2[1];
                    act[s + `RIS_NEG_OFFSET] = 1'b1;
                end else begin
                    src[s + `RIS_NEG_OFFSET] = 1'b0;
                    act[s + `RIS_NEG_OFFSET] = 1'b0;
                end
            end
            // gpio path never divides
            assign nodiv[s] = 1'b0;
            assign nodiv[s + `RIS_NEG_OFFSET] = (mode[s] == RIS_MODE_PIN);
            // receiver controls; swing only matters for diff receiver
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    rx_nmos[s] <= 1'b0;
                    rx_diff[s] <= 1'b0;
                end else begin
                    rx_diff[s] <= (mode[s] != RIS_MODE_DUAL) && act[s];
                    rx_nmos[s] <= swing_nmos[s] && (mode[s] != RIS_MODE_DUAL)
                                  && act[s];
                end
            end
        end
    endgenerate

    // one divider path per reference index, own edge and divider
    genvar r;
    generate
        for (r = 0; r < `RIS_NUM_REFS; r++) begin : g_ref
            ris_path_if pi ();
            assign pi.en     = act[r] && !ref_disable[r];
            assign pi.inv    = ref_invert[r];
            assign pi.bypass = div_bypass[r] || nodiv[r];
            assign pi.div    = div_count[r*`RIS_DIV_W +: `RIS_DIV_W];
            assign pi.ref_in = src[r];
            assign path_out[r] = pi.ref_out;
            ris_div_path u_path (
                .clk     (clk),
                .sys_rst (sys_rst),
                .p       (pi.path)
            );
            // route to clock or sync role
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    ref_clk[r]    <= 1'b0;
                    sync_pulse[r] <= 1'b0;
                    sync_ref[r*4 +: 4] <= 4'h0;
                end else begin
                    ref_clk[r]    <= path_out[r] && !sync_role[r];
                    sync_pulse[r] <= path_out[r] && sync_role[r];
                    sync_ref[r*4 +: 4] <= sync_role[r] ?
                                          sync_assoc[r*4 +: 4] : 4'h0;
                end
            end
        end
    endgenerate

    // nominal frequency fraction, registered per index
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            freq_m <= '0;
            freq_n <= '0;
        end else begin
            freq_m <= input_nominal_frequency_m;
            freq_n <= input_nominal_frequency_n;
        end
    end

    // system pll control load and rewrite
    logic              pll_dbl;   // loaded doubler
    logic [`RIS_FB_W-1:0] pll_fb; // loaded feedback
    logic              pll_rdy;   // load finished
    ris_pll_ctl u_pll (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .otp_en    (otp_en),
        .otp_valid (otp_valid),
        .otp_dbl   (otp_dbl),
        .otp_fb    (otp_fb),
        .eep_en    (eep_en),
        .eep_valid (eep_valid),
        .eep_dbl   (eep_dbl),
        .eep_fb    (eep_fb),
        .wr        (pll_wr),
        .wr_dbl    (pll_wr_dbl),
        .wr_fb     (pll_wr_fb),
        .dbl       (pll_dbl),
        .fb        (pll_fb),
        .ready     (pll_rdy)
    );

    // pll outputs and loss-of-lock alarm; no alarm before load ends
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            system_pll_doubler  <= 1'b0;
            system_pll_feedback <= `RIS_FB_RST;
            pll_ctl_ready       <= 1'b0;
            pll_lol_status      <= 1'b0;
            pll_lol_gpio        <= 1'b0;
        end else begin
            system_pll_doubler  <= pll_dbl;
            system_pll_feedback <= pll_fb;
            pll_ctl_ready       <= pll_rdy;
            pll_lol_status      <= pll_rdy && !lk_s2;
            pll_lol_gpio        <= pll_rdy && !lk_s2 && lol_route_en;
        end
    end

    chk_lol_route: assert property (@(posedge clk) disable iff (sys_rst)
        pll_lol_gpio |-> pll_lol_status && $past(lol_route_en))
        else $error("lol pin without status");
    chk_fb_range: assert property (@(posedge clk) disable iff (sys_rst)
        pll_ctl_ready && $past(pll_ctl_ready) |->
        system_pll_feedback >= 10'h06c && system_pll_feedback <= 10'h22c)
        else $error("feedback divider out of range");
    chk_off_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        ref_disable[0] [*3] |=> !ref_clk[0])
        else $error("disabled reference toggles");
    chk_sync_split: assert property (@(posedge clk) disable iff (sys_rst)
        !(ref_clk[8] && sync_pulse[8]))
        else $error("reference in both roles");
    chk_stage1_nopin: assert property (@(posedge clk) disable iff (sys_rst)
        stage_mode[3:2] == 2'h2 && ref_disable[9] == 1'b0 [*4] |=>
        !ref_clk[9] && !sync_pulse[9])
        else $error("pin mode on unpaired stage");
    chk_nmos_diff: assert property (@(posedge clk) disable iff (sys_rst)
        rx_nmos[0] |-> rx_diff[0])
        else $error("swing set on single-ended");
    cov_dual_mode: cover property (@(posedge clk) mode[0] == RIS_MODE_DUAL);
    cov_pin_mode: cover property (@(posedge clk) mode[0] == RIS_MODE_PIN);
    cov_lol: cover property (@(posedge clk) pll_lol_gpio);
endmodule : ris_input_stage
`default_nettype wire

// File: core/ris_cfg.svh
`ifndef RIS_CFG_SVH
`define RIS_CFG_SVH
`define RIS_NUM_STAGES   8
`define RIS_NUM_REFS     16
`define RIS_NEG_OFFSET   8
`define RIS_PIN0_STAGE   0
`define RIS_PIN3_STAGE   7
`define RIS_DIV_W        16
`define RIS_FREQ_M_W     48
`define RIS_FREQ_N_W     16
`define RIS_FB_MIN       10'h06c
`define RIS_FB_MAX       10'h22c
`define RIS_FB_W         10
`define RIS_FB_RST       10'h06c
`endif

// File: core/ris_pkg.sv
package ris_pkg;
    // input stage operating modes
    typedef enum logic [1:0] {
        RIS_MODE_DIFF = 2'h0,
        RIS_MODE_DUAL = 2'h1,
        RIS_MODE_PIN  = 2'h2
    } ris_mode_e;
    // pll control load states, one-hot
    typedef enum logic [3:0] {
        RIS_LD_IDLE = 4'h1,
        RIS_LD_OTP  = 4'h2,
        RIS_LD_EEP  = 4'h4,
        RIS_LD_RUN  = 4'h8
    } ris_ld_e;
endpackage : ris_pkg

// File: core/ris_path_if.sv
`timescale 1ns/1ns
`default_nettype none
// one divider path: configuration in, divided reference out
interface ris_path_if;
    logic        en;       // path enabled
    logic        inv;      // falling edge
    logic        bypass;   // divider bypass
    logic [15:0] div;      // count minus one
    logic        ref_in;   // synchronised sample
    logic        ref_out;  // path output
    modport ctl (output en, output inv, output bypass, output div,
                 output ref_in, input ref_out);
    modport path (input en, input inv, input bypass, input div,
                  input ref_in, output ref_out);
endinterface : ris_path_if
`default_nettype wire

// File: core/ris_div_path.sv
`timescale 1ns/1ns
`default_nettype none
`include "ris_cfg.svh"
// edge select, optional divide, disable gating for one path
module ris_div_path
    import ris_pkg::*;
(
    input  wire logic clk,
    input  wire logic sys_rst,
    ris_path_if.path  p
);
    logic                  sel;     // edge-selected input
    logic                  sel_d;   // previous sample
    logic [`RIS_DIV_W-1:0] cnt;     // edge counter
    logic                  tog;     // divided output
    logic                  rise;    // selected edge seen

    assign sel  = p.ref_in ^ p.inv; // inverted copy feeds divider
    assign rise = sel & ~sel_d;

    // edge history
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            // start at the idle level so invert gives no false edge
            sel_d <= sel;
        end else begin
            sel_d <= sel;
        end
    end

    // divide counter: toggle once every div+1 edges
    always_ff @(posedge clk) begin
        if (sys_rst || !p.en) begin
            cnt <= '0;
            tog <= 1'b0;
        end else if (rise) begin
            if (cnt >= p.div) begin
                cnt <= '0;
                tog <= ~tog;
            end else begin
                cnt <= cnt + 16'h0001;
            end
        end
    end

    // output: bypass passes the selected input straight
    // disabled path sits low so monitors see nothing
    always_ff @(posedge clk) begin
        if (sys_rst || !p.en) begin
            p.ref_out <= 1'b0;
        end else begin
            p.ref_out <= p.bypass ? sel : tog;
        end
    end

    chk_disable_low: assert property (@(posedge clk) disable iff (sys_rst)
        !p.en |=> !p.ref_out) else $error("disabled path output high");
    chk_bypass_follow: assert property (@(posedge clk) disable iff (sys_rst)
        p.en && p.bypass && $stable(p.en) |=> p.ref_out == $past(sel))
        else $error("bypass output does not follow input");
endmodule : ris_div_path
`default_nettype wire

// File: core/ris_pll_ctl.sv
`timescale 1ns/1ns
`default_nettype none
`include "ris_cfg.svh"
// system pll control load and host rewrite
module ris_pll_ctl
    import ris_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 otp_en,
    input  wire logic                 otp_valid,
    input  wire logic                 otp_dbl,
    input  wire logic [`RIS_FB_W-1:0] otp_fb,
    input  wire logic                 eep_en,
    input  wire logic                 eep_valid,
    input  wire logic                 eep_dbl,
    input  wire logic [`RIS_FB_W-1:0] eep_fb,
    input  wire logic                 wr,
    input  wire logic                 wr_dbl,
    input  wire logic [`RIS_FB_W-1:0] wr_fb,
    output logic                      dbl,
    output logic [`RIS_FB_W-1:0]      fb,
    output logic                      ready
);
    ris_ld_e st;  // load sequence state
    logic    fb_ok; // host value in range

    assign fb_ok = (wr_fb >= `RIS_FB_MIN) && (wr_fb <= `RIS_FB_MAX);

    // load sequence: otp first, eeprom only if otp not loaded, then run
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st    <= RIS_LD_IDLE;
            dbl   <= 1'b0;
            fb    <= `RIS_FB_RST;
            ready <= 1'b0;
        end else begin
            case (st)
                RIS_LD_IDLE: begin
                    st <= RIS_LD_OTP;
                end
                RIS_LD_OTP: begin
                    if (otp_en && otp_valid) begin
                        dbl <= otp_dbl;
                        fb  <= otp_fb;
                        st  <= RIS_LD_RUN;
                    end else begin
                        st  <= RIS_LD_EEP;
                    end
                end
                RIS_LD_EEP: begin
                    if (eep_en && eep_valid) begin
                        dbl <= eep_dbl;
                        fb  <= eep_fb;
                    end
                    st <= RIS_LD_RUN;
                end
                RIS_LD_RUN: begin
                    ready <= 1'b1;
                    // out-of-range feedback writes are dropped
                    if (wr && fb_ok) begin
                        dbl <= wr_dbl;
                        fb  <= wr_fb;
                    end
                end
                default: st <= RIS_LD_IDLE;
            endcase
        end
    end

    chk_host_write: assert property (@(posedge clk) disable iff (sys_rst)
        st == RIS_LD_RUN && wr && fb_ok |=> fb == $past(wr_fb))
        else $error("host pll write lost");
    chk_load_done: assert property (@(posedge clk) disable iff (sys_rst)
        st == RIS_LD_IDLE |-> ##[1:3] st == RIS_LD_RUN)
        else $error("pll load did not finish");
    cov_otp_load: cover property (@(posedge clk)
        st == RIS_LD_OTP && otp_en && otp_valid);
endmodule : ris_pll_ctl
`default_nettype wire

// File: verif/ris_ref_src_model.sv
`timescale 1ns/1ns
`default_nettype none
// reference sources: the selected pin bursts, with its complement on ref_n below index 8; all others sit low
module ris_ref_src_model #(
    parameter int HALF = 8 // clk cycles per source half period
) (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [3:0] sel,
    input  wire logic       use_gpio,
    input  wire logic [7:0] per,
    output logic [7:0]      ref_p,
    output logic [7:0]      ref_n,
    output logic            gpio0_in,
    output logic            gpio3_in,
    output logic            busy
);
    logic       lvl; // source level
    logic [3:0] s;   // index latched at burst start
    initial begin
        lvl = 1'b0;
        s = 4'h0;
        busy = 1'b0;
    end
    // burst; edges land 3 ns after clk so phase is unrelated
    always begin
        @(posedge clk iff go);
        s = sel;
        busy = 1'b1;
        repeat (2 * per) begin
            repeat (HALF) @(posedge clk);
            #3 lvl = ~lvl;
        end
        busy = 1'b0;
    end
    // idle pins held at the pull-down level, never at a stale value
    always @* begin
        ref_p = 8'h00;
        ref_n = 8'h00;
        gpio0_in = 1'b0;
        gpio3_in = 1'b0;
        if (!s[3]) begin
            ref_p[s[2:0]] = lvl;
            ref_n[s[2:0]] = busy & ~lvl; // complement only while driven
        end else if (use_gpio && s == 4'h8)
            gpio0_in = lvl;
        else if (use_gpio && s == 4'hf)
            gpio3_in = lvl;
        else
            ref_n[s[2:0]] = lvl;
    end
endmodule : ris_ref_src_model
`default_nettype wire

// File: verif/reference_input_stage_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "ris_cfg.svh"
module reference_input_stage_test
    import ris_pkg::*;
;
    typedef struct packed {
        ris_mode_e   mode; // stage mode
        logic [3:0]  idx;  // watched reference index
        logic [3:0]  flg;  // gpio, invert, bypass, disable
        logic [15:0] div;  // count minus one
        logic [7:0]  per;  // source periods
        logic [7:0]  tog;  // expected output toggles
        logic        lvl;  // expected final level
    } ris_row_s;
    logic         clk, sys_rst, gpio0_in, gpio3_in, go, use_gpio, busy;
    logic [7:0]   ref_p, ref_n, swing_nmos, rx_nmos, rx_diff, per;
    logic [15:0]  stage_mode, ref_disable, ref_invert, div_bypass;
    logic [15:0]  sync_role, ref_clk, sync_pulse;
    logic [255:0] div_count, nom_n, freq_n;
    logic [63:0]  sync_assoc, sync_ref;
    logic [767:0] nom_m, freq_m;
    logic         otp_en, otp_valid, otp_dbl, eep_en, eep_valid, eep_dbl;
    logic         pll_wr, pll_wr_dbl, pll_lock, lol_route_en, last;
    logic         dbl, rdy, lol_st, lol_gp;
    logic [9:0]   otp_fb, eep_fb, pll_wr_fb, fb;
    logic [3:0]   sel;
    int           errors, n_checks, tog, k;
    ris_row_s     rows [10];

    ris_input_stage i_dut (
        .clk(clk), .sys_rst(sys_rst), .ref_p(ref_p), .ref_n(ref_n),
        .gpio0_in(gpio0_in), .gpio3_in(gpio3_in), .stage_mode(stage_mode),
        .swing_nmos(swing_nmos), .ref_disable(ref_disable),
        .ref_invert(ref_invert), .div_bypass(div_bypass),
        .div_count(div_count), .sync_role(sync_role),
        .sync_assoc(sync_assoc), .input_nominal_frequency_m(nom_m),
        .input_nominal_frequency_n(nom_n), .otp_en(otp_en),
        .otp_valid(otp_valid), .otp_dbl(otp_dbl), .otp_fb(otp_fb),
        .eep_en(eep_en), .eep_valid(eep_valid), .eep_dbl(eep_dbl),
        .eep_fb(eep_fb), .pll_wr(pll_wr), .pll_wr_dbl(pll_wr_dbl),
        .pll_wr_fb(pll_wr_fb), .pll_lock(pll_lock),
        .lol_route_en(lol_route_en), .ref_clk(ref_clk),
        .sync_pulse(sync_pulse), .sync_ref(sync_ref), .rx_nmos(rx_nmos),
        .rx_diff(rx_diff), .freq_m(freq_m), .freq_n(freq_n),
        .system_pll_doubler(dbl), .system_pll_feedback(fb),
        .pll_ctl_ready(rdy), .pll_lol_status(lol_st), .pll_lol_gpio(lol_gp)
    );
    ris_ref_src_model i_src (
        .clk(clk), .go(go), .sel(sel), .use_gpio(use_gpio), .per(per),
        .ref_p(ref_p), .ref_n(ref_n), .gpio0_in(gpio0_in),
        .gpio3_in(gpio3_in), .busy(busy)
    );
    // free-running 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // counts toggles of the watched reference output
    always @(negedge clk) begin
        if (ref_clk[sel] !== last) tog++;
        last = ref_clk[sel];
    end
    task automatic cmp_num(input logic [47:0] got, input logic [47:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t got %0h want %0h", $time, got, exp);
        end
    endtask : cmp_num
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_num(48'(got), 48'(exp));
    endtask : cmp_bit
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    // bounded wait for the pll control load to finish
    task automatic wait_rdy();
        for (k = 0; k < 50 && rdy !== 1'b1; k++) @(negedge clk);
        cmp_bit(rdy, 1'b1);
    endtask : wait_rdy
    // reset, configure one stage, burst its source, count output edges
    task automatic run_row(input ris_row_s r);
        sys_rst = 1'b1;
        stage_mode = '0;
        stage_mode[2*r.idx[2:0]+:2] = r.mode;
        ref_disable = 16'(r.flg[0]) << r.idx;
        div_bypass = 16'(r.flg[1]) << r.idx;
        ref_invert = 16'(r.flg[2]) << r.idx;
        div_count[16*r.idx+:16] = r.div;
        use_gpio = r.flg[3];
        sel = r.idx;
        per = r.per;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        repeat (6) @(negedge clk);
        tog = 0;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        for (k = 0; k < 3000 && busy !== 1'b0; k++) @(negedge clk);
        cmp_bit(busy, 1'b0);
        repeat (10) @(negedge clk);
        cmp_num(48'(tog), 48'(r.tog));
        cmp_bit(ref_clk[r.idx], r.lvl);
    endtask : run_row
    // pulse one host write of the feedback divider
    task automatic wr_pll(input logic [9:0] f, input logic [9:0] e);
        pll_wr = 1'b1;
        pll_wr_fb = f;
        @(negedge clk);
        pll_wr = 1'b0;
        repeat (3) @(negedge clk);
        cmp_num(48'(fb), 48'(e));
    endtask : wr_pll
    // watchdog sized well beyond the expected run of about 800 cycles
    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        summarize();
    end
    initial begin
        {sys_rst, otp_en, otp_valid, otp_dbl, pll_lock, lol_route_en} = '1;
        {eep_en, eep_valid, eep_dbl, pll_wr, pll_wr_dbl, go, use_gpio} = '0;
        {stage_mode, swing_nmos, ref_disable, ref_invert} = '0;
        {div_bypass, div_count, sync_role, sync_assoc, nom_m, nom_n} = '0;
        {otp_fb, eep_fb, pll_wr_fb} = {10'h0c8, 10'h12c, 10'h06c};
        {sel, per, last, errors, n_checks, tog} = '0;
        rows = '{
            '{RIS_MODE_DIFF, 4'h0, 4'b0010, 16'h0, 8'h3, 8'h6, 1'b0},
            '{RIS_MODE_DIFF, 4'h2, 4'b0110, 16'h0, 8'h3, 8'h6, 1'b1},
            '{RIS_MODE_DUAL, 4'h9, 4'b0010, 16'h0, 8'h3, 8'h6, 1'b0},
            '{RIS_MODE_DUAL, 4'h1, 4'b0000, 16'h1, 8'h4, 8'h2, 1'b0},
            '{RIS_MODE_DUAL, 4'h3, 4'b0100, 16'h2, 8'h6, 8'h2, 1'b0},
            '{RIS_MODE_PIN, 4'h8, 4'b1000, 16'h3, 8'h3, 8'h6, 1'b0},
            '{RIS_MODE_PIN, 4'hf, 4'b1110, 16'h0, 8'h3, 8'h6, 1'b1},
            '{RIS_MODE_DUAL, 4'h8, 4'b1010, 16'h0, 8'h3, 8'h0, 1'b0},
            '{RIS_MODE_PIN, 4'h1, 4'b0010, 16'h0, 8'h3, 8'h6, 1'b0},
            '{RIS_MODE_DIFF, 4'h0, 4'b0011, 16'h0, 8'h3, 8'h0, 1'b0}
        };
        repeat (20) @(negedge clk);
        cmp_num(48'(fb), 48'h6c);
        cmp_num(48'({ref_clk, rdy}), 48'h0);
        foreach (rows[i]) run_row(rows[i]);
        wait_rdy();
        cmp_num(48'({dbl, fb}), 48'h4c8);
        wr_pll(10'h22c, 10'h22c);
        wr_pll(10'h22d, 10'h22c);
        wr_pll(10'h06b, 10'h22c);
        wr_pll(10'h06c, 10'h06c);
        cmp_bit(dbl, 1'b0);
        // second source: otp empty, eeprom valid
        {otp_valid, eep_en, eep_valid, sys_rst} = 4'h7;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        wait_rdy();
        cmp_num(48'(fb), 48'h12c);
        pll_lock = 1'b0;
        repeat (6) @(negedge clk);
        cmp_num(48'({lol_st, lol_gp}), 48'h3);
        lol_route_en = 1'b0;
        repeat (3) @(negedge clk);
        cmp_bit(lol_gp, 1'b0);
        nom_m[48*5+:48] = 48'hfedc_ba98_7654;
        nom_n[16*5+:16] = 16'h009e;
        sync_role[4] = 1'b1;
        sync_assoc[16+:4] = 4'h2;
        ref_invert = 16'h0010;
        div_bypass = 16'h0010;
        stage_mode[5:4] = RIS_MODE_DIFF;
        swing_nmos[2] = 1'b1;
        repeat (3) @(negedge clk);
        cmp_num(freq_m[48*5+:48], 48'hfedc_ba98_7654);
        cmp_num(48'(freq_n[16*5+:16]), 48'h9e);
        cmp_num(48'(sync_ref[16+:4]), 48'h2);
        cmp_num(48'({sync_pulse[4], ref_clk[4]}), 48'h2);
        cmp_num(48'({rx_nmos[2], rx_diff[2]}), 48'h3);
        stage_mode[5:4] = RIS_MODE_DUAL;
        repeat (3) @(negedge clk);
        cmp_num(48'({rx_nmos[2], rx_diff[2]}), 48'h0);
        summarize();
    end
endmodule : reference_input_stage_test
`default_nettype wire
